// [common/ras_defs.svh]
// Constants of the return address stack: offsets, field positions, sizes
`ifndef RAS_DEFS_SVH
`define RAS_DEFS_SVH

// Sizes of the stack and its words
`define RAS_DEPTH        31
`define RAS_PTR_W        5
`define RAS_PC_W         21
`define RAS_ADDR_W       8
`define RAS_DATA_W       32

// Pointer values with a meaning of their own
`define RAS_PTR_EMPTY    5'h00
`define RAS_PTR_LAST     5'h1f
`define RAS_PTR_NEARLAST 5'h1e
`define RAS_PTR_STEP     5'h01

// Step from a pushed address to the next instruction
`define RAS_PC_STEP      21'h000002

// Register byte offsets on the bus
`define RAS_OFF_PTR      8'h00
`define RAS_OFF_UPPER    8'h04
`define RAS_OFF_HIGH     8'h08
`define RAS_OFF_LOW      8'h0c

// Field positions in the pointer register
`define RAS_BIT_UNF      6
`define RAS_BIT_FUL      7

// Field positions of the top-of-stack bytes in a 21-bit word
`define RAS_UPPER_HI     20
`define RAS_UPPER_LO     16
`define RAS_HIGH_HI      15
`define RAS_HIGH_LO      8
`define RAS_LOW_HI       7
`define RAS_LOW_LO       0

`endif

// [common/ras_pkg.sv]
// Types shared by the return address stack and its users
`include "ras_defs.svh"
package ras_pkg;

  // Saved core registers of the fast register stack
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] work;
    logic [7:0] bank;
  } ras_shadow_t;

  // Request from the instruction sequencer
  typedef struct packed {
    logic                 push;      // Call, relative call or interrupt entry
    logic                 pop;       // Any return
    logic                 intVector; // Processor vectors to an interrupt
    logic                 fastCall;  // Call with the fast option
    logic                 fastRet;   // Return with the fast option
    logic [`RAS_PC_W-1:0] pc;        // Program counter to push
  } ras_core_req_t;

  // Answer to the instruction sequencer
  typedef struct packed {
    logic                 popValid;     // Popped address is valid
    logic [`RAS_PC_W-1:0] popPc;        // Address loaded into the program counter
    logic                 restoreValid; // Shadow contents are valid
    ras_shadow_t          restore;      // Values to load back
    logic                 overflowReset; // Device reset request
  } ras_core_rsp_t;

endpackage : ras_pkg

// [rtl/ras_return_stack.sv]
// Return address stack with fast register shadow and APB register access
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ras_defs.svh"

module ras_return_stack (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       porRst,
  input  wire logic                       ce,
  input  wire logic                       overflowResetEnable,
  input  wire ras_pkg::ras_core_req_t     coreReq,
  input  wire ras_pkg::ras_shadow_t       coreRegs,
  output var  ras_pkg::ras_core_rsp_t     coreRsp,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`RAS_ADDR_W-1:0]     paddr,
  input  wire logic [`RAS_DATA_W-1:0]     pwdata,
  output logic      [`RAS_DATA_W-1:0]     prdata,
  output logic                            pready,
  output logic                            pslverr
);

  // ************************************************************
  // State of the block
  // ************************************************************

  // All storage of the block in one record
  typedef struct packed {
    logic [`RAS_DEPTH:1][`RAS_PC_W-1:0] stackMem;     // Entries 1..31
    logic [`RAS_PTR_W-1:0]              ptr;          // Stack pointer
    logic                               fullFlag;     // Stack full
    logic                               underFlag;    // Stack underflow
    ras_pkg::ras_shadow_t               shadow;       // Fast register stack
    ras_pkg::ras_core_rsp_t             rsp;          // Answer to the core
    logic                               apbAck;       // Access phase answered
    logic [`RAS_DATA_W-1:0]             rdData;       // Read data held
    logic                               slvErr;       // Error held
  } ras_state_t;

  ras_state_t st_reg;   // Registered state
  ras_state_t st_next;  // Next state

  // ************************************************************
  // Combinational helpers
  // ************************************************************

  logic                  apbAccess;  // Access phase present
  logic                  apbWrite;   // Write takes effect now
  logic                  hitPtr;     // Pointer register selected
  logic                  hitUpper;   // Upper byte selected
  logic                  hitHigh;    // High byte selected
  logic                  hitLow;     // Low byte selected
  logic                  hitAny;     // Any register selected
  logic [`RAS_PC_W-1:0]  tosWord;    // Entry under the pointer
  logic [`RAS_DATA_W-1:0] rdMux;     // Read data for this address

  // Phase decode of the bus transfer
  assign apbAccess = psel & penable;
  assign apbWrite  = apbAccess & pwrite & st_reg.apbAck;

  // Address decode
  // Only four word addresses are mapped; every other address selects
  // nothing and is answered with an error so that software notices a
  // stray access instead of silently reading zero.
  always_comb begin
    hitPtr   = 1'b0;
    hitUpper = 1'b0;
    hitHigh  = 1'b0;
    hitLow   = 1'b0;
    if (paddr == `RAS_OFF_PTR) begin
      // Pointer and status flags
      hitPtr = 1'b1;
    end else if (paddr == `RAS_OFF_UPPER) begin
      // Bits 20..16 of the top entry
      hitUpper = 1'b1;
    end else if (paddr == `RAS_OFF_HIGH) begin
      // Bits 15..8 of the top entry
      hitHigh = 1'b1;
    end else if (paddr == `RAS_OFF_LOW) begin
      // Bits 7..0 of the top entry
      hitLow = 1'b1;
    end
  end

  // Any mapped register; the inverse becomes the error answer
  assign hitAny = hitPtr | hitUpper | hitHigh | hitLow;

  // Entry under the pointer; pointer zero has nothing behind it
  always_comb begin
    tosWord = '0;
    if (st_reg.ptr != `RAS_PTR_EMPTY) begin
      tosWord = st_reg.stackMem[st_reg.ptr];
    end
  end

  // Read data multiplexer
  // Each register sits in the low bits of its word; the bits above it
  // read as zero. Bit 5 of the pointer word is unused and reads zero.
  // The value is taken in the first access cycle and held in flip-flops
  // until the answer cycle, so a core push or pop in the wait state does
  // not tear the word that software sees.
  always_comb begin
    rdMux = '0;
    if (hitPtr) begin
      // Pointer with both sticky flags
      rdMux[`RAS_PTR_W-1:0] = st_reg.ptr;
      rdMux[`RAS_BIT_UNF]   = st_reg.underFlag;
      rdMux[`RAS_BIT_FUL]   = st_reg.fullFlag;
    end else if (hitUpper) begin
      // Upper five bits of the addressed entry
      rdMux[`RAS_UPPER_HI-`RAS_UPPER_LO:0] = tosWord[`RAS_UPPER_HI:`RAS_UPPER_LO];
    end else if (hitHigh) begin
      // Middle byte of the addressed entry
      rdMux[`RAS_HIGH_HI-`RAS_HIGH_LO:0] = tosWord[`RAS_HIGH_HI:`RAS_HIGH_LO];
    end else if (hitLow) begin
      // Low byte of the addressed entry
      rdMux[`RAS_LOW_HI-`RAS_LOW_LO:0] = tosWord[`RAS_LOW_HI:`RAS_LOW_LO];
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************

  always_comb begin
    st_next = st_reg;

    // Answers to the core last one cycle
    st_next.rsp.popValid      = 1'b0;
    st_next.rsp.restoreValid  = 1'b0;
    st_next.rsp.overflowReset = 1'b0;

    // Bus slave: one wait state, then the answer
    if (apbAccess && !st_reg.apbAck) begin
      st_next.apbAck = 1'b1;
      st_next.rdData = pwrite ? '0 : rdMux;
      st_next.slvErr = ~hitAny;
    end else begin
      st_next.apbAck = 1'b0;
      st_next.rdData = '0;
      st_next.slvErr = 1'b0;
    end

    // Software writes to the pointer and the top entry
    if (apbWrite && hitPtr) begin
      st_next.ptr = pwdata[`RAS_PTR_W-1:0];
      // Writing zero clears a flag, one leaves it alone
      if (!pwdata[`RAS_BIT_FUL]) begin
        st_next.fullFlag = 1'b0;
      end
      if (!pwdata[`RAS_BIT_UNF]) begin
        st_next.underFlag = 1'b0;
      end
    end else if (apbWrite && st_reg.ptr != `RAS_PTR_EMPTY) begin
      // Top-of-stack byte writes replace part of the entry.
      // With the pointer at zero there is no entry behind it, so such
      // writes are dropped. Software should keep interrupts masked while
      // it edits the top entry, or a push may move the pointer between
      // two byte writes and split the address over two entries.
      if (hitUpper) begin
        st_next.stackMem[st_reg.ptr][`RAS_UPPER_HI:`RAS_UPPER_LO] =
          pwdata[`RAS_UPPER_HI-`RAS_UPPER_LO:0];
      end else if (hitHigh) begin
        st_next.stackMem[st_reg.ptr][`RAS_HIGH_HI:`RAS_HIGH_LO] =
          pwdata[`RAS_HIGH_HI-`RAS_HIGH_LO:0];
      end else if (hitLow) begin
        st_next.stackMem[st_reg.ptr][`RAS_LOW_HI:`RAS_LOW_LO] =
          pwdata[`RAS_LOW_HI-`RAS_LOW_LO:0];
      end
    end

    // Core operations; they come after the bus writes and override a pointer
    // write except on a pop from an empty stack, and a flag set here wins over a clear above.
    // The block holds only the stack: program counter latches are
    // elsewhere and untouched by these operations.
    if (coreReq.push) begin
      if (st_reg.ptr == `RAS_PTR_LAST) begin
        // Stack already full: no overwrite, no advance
        st_next.ptr      = `RAS_PTR_LAST;
        st_next.fullFlag = 1'b1;
      end else if (st_reg.ptr == `RAS_PTR_NEARLAST) begin
        // The 31st push fills the last entry
        st_next.fullFlag = 1'b1;
        if (overflowResetEnable) begin
          st_next.stackMem[`RAS_PTR_LAST] = coreReq.pc + `RAS_PC_STEP;
          st_next.ptr                     = `RAS_PTR_EMPTY;
          st_next.rsp.overflowReset       = 1'b1;
        end else begin
          st_next.stackMem[`RAS_PTR_LAST] = coreReq.pc;
          st_next.ptr                     = `RAS_PTR_LAST;
        end
      end else begin
        // Increment first, then write the new top entry
        st_next.ptr = st_reg.ptr + `RAS_PTR_STEP;
        st_next.stackMem[st_reg.ptr + `RAS_PTR_STEP] = coreReq.pc;
      end
    end else if (coreReq.pop) begin
      st_next.rsp.popValid = 1'b1;
      if (st_reg.ptr == `RAS_PTR_EMPTY) begin
        // Empty stack: vector to zero, pointer stays
        st_next.rsp.popPc = '0;
        st_next.underFlag = 1'b1;
      end else begin
        // Read the entry first, then decrement
        st_next.rsp.popPc = st_reg.stackMem[st_reg.ptr];
        st_next.ptr       = st_reg.ptr - `RAS_PTR_STEP;
      end
    end

    // Fast register stack: one deep, loaded on any vector or fast call
    if (coreReq.intVector || coreReq.fastCall) begin
      st_next.shadow = coreRegs;
    end

    // Fast return hands the saved values back
    if (coreReq.fastRet) begin
      st_next.rsp.restore      = st_reg.shadow;
      st_next.rsp.restoreValid = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************

  // Power-on reset clears everything; other resets spare the flags,
  // the entries and the shadow
  always_ff @(posedge clk) begin
    if (porRst) begin
      st_reg <= '0;
    end else if (rst) begin
      st_reg.ptr    <= `RAS_PTR_EMPTY;
      st_reg.rsp    <= '0;
      st_reg.apbAck <= 1'b0;
      st_reg.rdData <= '0;
      st_reg.slvErr <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  assign coreRsp = st_reg.rsp;     // Registered core answer
  assign pready  = st_reg.apbAck;  // Registered bus answer
  assign prdata  = st_reg.rdData;  // Read data from flip-flops
  assign pslverr = st_reg.slvErr;  // Unmapped address answer

endmodule : ras_return_stack
`default_nettype wire

// [test/ras_core_model.sv]
// Partner model of the core sequencer that raises stack events
`timescale 1ns/1ps
`default_nettype none
module ras_core_model (
  input  wire logic                   clk,
  output var  ras_pkg::ras_core_req_t coreReq,
  output var  ras_pkg::ras_shadow_t   coreRegs
);
  // Quiet link at time zero
  initial coreReq = '0;
  initial coreRegs = '0;
  // One event pulse, then an idle cycle; no events while software holds the top bytes
  task op(input logic [4:0] k, input logic [20:0] p, input logic [23:0] s);
    @(posedge clk);
    coreReq <= {k, p};
    coreRegs <= s;
    @(posedge clk);
    // Stale values are inverted so a late sample shows up
    coreReq <= {5'h00, ~p};
    coreRegs <= ~s;
  endtask : op
endmodule : ras_core_model
`default_nettype wire

// [test/ras_return_stack_chk.sv]
// Port assertions of the return address stack
`timescale 1ns/1ps
`default_nettype none
module ras_return_stack_chk (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   porRst,
  input wire logic                   ce,
  input wire ras_pkg::ras_core_req_t coreReq,
  input wire ras_pkg::ras_shadow_t   coreRegs,
  input wire ras_pkg::ras_core_rsp_t coreRsp,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr
);
  // ************ Clock and reset of every check ************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || porRst);
  // ************ Bus answers ************
  apb_wait_a:
    assert property ((ce && psel && !penable) ##1 (ce && psel && penable) |=> pready)
    else $error("bus answer late");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("ready held");
  read_idle_a:
    assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  // ************ Core answers ************
  pop_answer_a:
    assert property (ce && coreReq.pop && !coreReq.push |=> coreRsp.popValid)
    else $error("pop not answered");
  pop_cause_a:
    assert property (coreRsp.popValid |-> $past(ce && coreReq.pop)) else $error("stray pop");
  restore_answer_a:
    assert property (ce && coreReq.fastRet |=> coreRsp.restoreValid)
    else $error("fast return not answered");
  shadow_value_a:
    assert property ((ce && (coreReq.intVector || coreReq.fastCall)) ##1
      !(coreReq.intVector || coreReq.fastCall) ##1 (ce && coreReq.fastRet && !coreReq.intVector
      && !coreReq.fastCall) |=> coreRsp.restore == $past(coreRegs, 3))
    else $error("shadow value wrong");
  ovf_cause_a:
    assert property (coreRsp.overflowReset |-> $past(ce && coreReq.push))
    else $error("stray overflow reset");
  ce_freeze_a:
    assert property (!ce |=> $stable(coreRsp) && $stable(pready) && $stable(prdata))
    else $error("state moved while clock enable low");
  // ************ Main scenarios ************
  pop_c: cover property (coreRsp.popValid);
  ovf_c: cover property (coreRsp.overflowReset);
  err_c: cover property (pslverr);
  restore_c: cover property (coreRsp.restoreValid);
endmodule : ras_return_stack_chk
bind ras_return_stack ras_return_stack_chk uChk (.clk(clk), .rst(rst), .porRst(porRst),
  .ce(ce), .coreReq(coreReq), .coreRegs(coreRegs), .coreRsp(coreRsp), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [test/tb.sv]
// Self-checking bench of the return address stack
`timescale 1ns/1ps
`default_nettype none
`include "ras_defs.svh"
module tb;
  // ************ Signals ************
  logic clk = 1'b0, rst = 1'b1, porRst = 1'b1, ce = 1'b1, ore = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  ras_pkg::ras_core_req_t coreReq;
  ras_pkg::ras_shadow_t coreRegs;
  ras_pkg::ras_core_rsp_t coreRsp;
  logic [32:0] popQ[$], rdQ[$], resQ[$]; // Expected results in order
  logic [20:0] pcs[33];
  logic [23:0] sv;
  int err_total = 0, total_checks = 0, cyc = 0, ovfSeen = 0, i;
  always #25 clk = ~clk;
  ras_core_model core (.clk(clk), .coreReq(coreReq), .coreRegs(coreRegs));
  ras_return_stack dut (.clk(clk), .rst(rst), .porRst(porRst), .ce(ce),
    .overflowResetEnable(ore), .coreReq(coreReq), .coreRegs(coreRegs), .coreRsp(coreRsp),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ************ Tasks ************
  task chk(input logic [32:0] g, input logic [32:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH time=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One bus transfer, held until ready is sampled
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [32:0] e);
    rdQ.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd
  task push(input int n);
    pcs[n] = 21'($urandom()) & 21'h1ffffe;
    core.op(5'h10, pcs[n], 24'h0);
  endtask : push
  task pop(input int n);
    popQ.push_back({12'h0, pcs[n]});
    core.op(5'h08, 21'h0, 24'h0);
  endtask : pop
  // Short reset pulse, power-on or plain
  task pulse(input logic por);
    @(posedge clk);
    if (por) porRst <= 1'b1;
    else rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    porRst <= 1'b0;
  endtask : pulse
  task summarize();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // ************ Watcher: oldest note against each answer ************
  always @(posedge clk) begin
    cyc++;
    if (coreRsp.popValid === 1'b1) chk({12'h0, coreRsp.popPc}, popQ.pop_front());
    if (coreRsp.restoreValid === 1'b1) chk({9'h0, coreRsp.restore}, resQ.pop_front());
    if (pready === 1'b1 && pwrite === 1'b0) chk({pslverr, prdata}, rdQ.pop_front());
    if (coreRsp.overflowReset === 1'b1) ovfSeen++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  // ************ Main sequence ************
  initial begin
    i = $urandom(32'h0701);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    porRst <= 1'b0;
    pcs[0] = 21'h0;
    rd(`RAS_OFF_PTR, 33'h0);
    rd(`RAS_OFF_LOW, 33'h0);
    rd(8'h10, 33'h100000000);
    // A push while the clock enable is low must be lost
    ce <= 1'b0;
    core.op(5'h10, 21'h1, 24'h0);
    ce <= 1'b1;
    rd(`RAS_OFF_PTR, 33'h0);
    for (i = 1; i <= 4; i++) push(i);
    rd(`RAS_OFF_PTR, 33'h4);
    rd(`RAS_OFF_UPPER, {28'h0, pcs[4][20:16]});
    rd(`RAS_OFF_HIGH, {25'h0, pcs[4][15:8]});
    apb(`RAS_OFF_LOW, 1'b1, 32'h5a);
    pcs[4][7:0] = 8'h5a;
    for (i = 4; i >= 0; i--) pop(i);
    rd(`RAS_OFF_PTR, 33'h40);
    pulse(1'b0);
    rd(`RAS_OFF_PTR, 33'h40);
    apb(`RAS_OFF_PTR, 1'b1, 32'h0);
    rd(`RAS_OFF_PTR, 33'h0);
    for (i = 1; i <= 32; i++) push(i);
    rd(`RAS_OFF_PTR, 33'h9f);
    pop(31);
    apb(`RAS_OFF_PTR, 1'b1, 32'h0);
    ore <= 1'b1;
    for (i = 1; i <= 31; i++) push(i);
    rd(`RAS_OFF_PTR, 33'h80);
    apb(`RAS_OFF_PTR, 1'b1, 32'h9f);
    pcs[31] = pcs[31] + `RAS_PC_STEP;
    rd(`RAS_OFF_LOW, {25'h0, pcs[31][7:0]});
    pulse(1'b0);
    rd(`RAS_OFF_PTR, 33'h80);
    pulse(1'b1);
    rd(`RAS_OFF_PTR, 33'h0);
    chk(33'(ovfSeen), 33'h1);
    // Two vectors in a row and a fast return, then a fast call and a fast return
    sv = 24'($urandom());
    core.op(5'h04, 21'h0, ~sv);
    core.op(5'h04, 21'h0, sv);
    resQ.push_back({9'h0, sv});
    core.op(5'h01, 21'h0, 24'h0);
    sv = 24'($urandom());
    core.op(5'h02, 21'h0, sv);
    resQ.push_back({9'h0, sv});
    core.op(5'h01, 21'h0, 24'h0);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule : tb
`default_nettype wire
